//--- hw/acls_regs.sv
// Audio path configuration and serial link status register slice
`timescale 1ns/10ps
module acls_regs #(
    parameter int SETTLE_T2_CYCLES = acls_pkg::SETTLE_T2_CYC,
    parameter int SETTLE_T3_CYCLES = acls_pkg::SETTLE_T3_CYC
) (
    input  wire logic                             sys_clk,
    input  wire logic                             rst_n,
    // Register port
    input  wire logic [7:0]                       reg_addr,
    input  wire logic                             reg_wr,
    input  wire logic [7:0]                       reg_wdata,
    input  wire logic                             reg_rd,
    output logic      [7:0]                       reg_rdata,
    output logic                                  reg_rvalid,
    // Bridge configuration from outside this slice
    input  wire logic                             audio_src_local,
    // Packet fields from the HDMI receiver
    input  wire logic                             audio_type_valid,
    input  wire logic [acls_pkg::AUDIO_TYPE_W-1:0] audio_type,
    input  wire logic                             sound_frame_valid,
    input  wire logic [acls_pkg::CHECKSUM_W-1:0]   sound_frame_csum,
    input  wire logic                             video_frame_valid,
    input  wire logic [acls_pkg::CHECKSUM_W-1:0]   video_frame_csum,
    input  wire logic                             regen_packet_valid,
    input  wire logic [acls_pkg::REGEN_NCTS_W-1:0] regen_n_cts,
    // Link and receiver conditions
    input  wire logic                             link_detected,
    input  wire logic                             link_caps_known,
    input  wire logic                             tx_active,
    input  wire logic                             remote_locked,
    input  wire logic                             input_valid,
    input  wire logic                             port_mode_ok,
    input  wire logic                             port0_single,
    input  wire logic                             tmds_recovering,
    input  wire logic                             hdmi_pll_locked,
    // Frequency measurement and its settings
    input  wire logic                             freq_meas_valid,
    input  wire logic [acls_pkg::FREQ_W-1:0]       freq_mhz,
    input  wire logic [acls_pkg::LOW_LIMIT_W-1:0]  low_rate_limit,
    input  wire logic [acls_pkg::TOLERANCE_W-1:0]  rate_tolerance,
    input  wire logic [1:0]                       settle_time_select,
    // Audio path controls and link status register
    output logic                                  tdm_conv_enable,
    output logic                                  audio_clk_from_conv,
    output logic                                  i2s_out_enable,
    output logic                                  audio_from_local_pins,
    output logic                                  fifo_clear,
    output logic [7:0]                            serial_link_state
);

    // ************************************************************
    // Control register
    // ************************************************************
    logic [7:0] sound_path_control;
    wire        wr_ctl  = reg_wr && (reg_addr == acls_pkg::SOUND_PATH_CONTROL_ADDR);
    wire        rd_ctl  = reg_addr == acls_pkg::SOUND_PATH_CONTROL_ADDR;
    wire        rd_sts  = reg_addr == acls_pkg::SERIAL_LINK_STATE_ADDR;
    wire [7:0]  next_ctl = reg_wdata & acls_pkg::SOUND_PATH_CONTROL_MASK;

    // Only the control address is writable; status writes fall through
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sound_path_control <= acls_pkg::SOUND_PATH_CONTROL_RST;
        else if (wr_ctl)
            sound_path_control <= next_ctl;
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // Unmapped addresses answer zero, so software sees no stale data
    wire [7:0] next_rdata = rd_ctl ? sound_path_control :
                            rd_sts ? serial_link_state : 8'h00;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Audio path decode
    // ************************************************************
    wire tdm_on  = sound_path_control[acls_pkg::CTL_TDM_TO_PARALLEL_BIT];
    // Pin drive only makes sense when HDMI is the audio source
    wire i2s_on  = sound_path_control[acls_pkg::CTL_HDMI_I2S_OUT_BIT] && !audio_src_local;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            tdm_conv_enable       <= 1'b0;
            audio_clk_from_conv   <= 1'b0;
            i2s_out_enable        <= 1'b0;
            audio_from_local_pins <= 1'b0;
        end
        else
        begin
            tdm_conv_enable       <= tdm_on;
            audio_clk_from_conv   <= tdm_on;
            i2s_out_enable        <= i2s_on;
            audio_from_local_pins <= audio_src_local;
        end
    end

    // ************************************************************
    // Audio FIFO clear triggers
    // ************************************************************
    acls_trig_if trig_type ();
    acls_trig_if trig_sound ();
    acls_trig_if trig_video ();
    acls_trig_if trig_regen ();

    assign trig_type.en  = sound_path_control[acls_pkg::CTL_FIFO_CLEAR_ON_TYPE_BIT];
    assign trig_sound.en = sound_path_control[acls_pkg::CTL_FIFO_CLEAR_ON_SOUND_BIT];
    assign trig_video.en = sound_path_control[acls_pkg::CTL_FIFO_CLEAR_ON_VIDEO_BIT];
    assign trig_regen.en = sound_path_control[acls_pkg::CTL_FIFO_CLEAR_ON_REGEN_BIT];

    acls_change_det #(.W(acls_pkg::AUDIO_TYPE_W)) u_det_type (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sample_valid (audio_type_valid),
        .sample       (audio_type),
        .trig         (trig_type.det)
    );

    acls_change_det #(.W(acls_pkg::CHECKSUM_W)) u_det_sound (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sample_valid (sound_frame_valid),
        .sample       (sound_frame_csum),
        .trig         (trig_sound.det)
    );

    acls_change_det #(.W(acls_pkg::CHECKSUM_W)) u_det_video (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sample_valid (video_frame_valid),
        .sample       (video_frame_csum),
        .trig         (trig_video.det)
    );

    acls_change_det #(.W(acls_pkg::REGEN_NCTS_W)) u_det_regen (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .sample_valid (regen_packet_valid),
        .sample       (regen_n_cts),
        .trig         (trig_regen.det)
    );

    // Hits from several watchers in one cycle merge into a single clear
    wire any_hit = trig_type.hit || trig_sound.hit || trig_video.hit || trig_regen.hit;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            fifo_clear <= 1'b0;
        else
            fifo_clear <= any_hit;
    end

    // ************************************************************
    // Frequency detector
    // ************************************************************
    logic [acls_pkg::FREQ_W-1:0]       ref_freq;
    logic [acls_pkg::SETTLE_CNT_W-1:0] settle_cnt;

    wire [acls_pkg::FREQ_W-1:0] freq_diff = (freq_mhz > ref_freq) ? (freq_mhz - ref_freq)
                                                                   : (ref_freq - freq_mhz);
    // Small wobble below the tolerance keeps the old reference
    wire freq_moved = freq_meas_valid &&
                      (freq_diff > {{(acls_pkg::FREQ_W-acls_pkg::TOLERANCE_W){1'b0}}, rate_tolerance});
    // Limit compares in MHz, so it can change at any time without a restart
    wire no_clk     = freq_mhz <= {{(acls_pkg::FREQ_W-acls_pkg::LOW_LIMIT_W){1'b0}}, low_rate_limit};

    wire [acls_pkg::SETTLE_CNT_W-1:0] settle_limit =
        (settle_time_select == 2'h0) ? acls_pkg::SETTLE_CNT_W'(acls_pkg::SETTLE_T0_CYC) :
        (settle_time_select == 2'h1) ? acls_pkg::SETTLE_CNT_W'(acls_pkg::SETTLE_T1_CYC) :
        (settle_time_select == 2'h2) ? acls_pkg::SETTLE_CNT_W'(SETTLE_T2_CYCLES) :
                                       acls_pkg::SETTLE_CNT_W'(SETTLE_T3_CYCLES);
    wire rate_settled = (settle_cnt >= settle_limit) && !no_clk;

    // Counter restarts on any move or when the clock is missing
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ref_freq   <= '0;
            settle_cnt <= '0;
        end
        else if (freq_moved || no_clk)
        begin
            ref_freq   <= freq_mhz;
            settle_cnt <= '0;
        end
        else if (settle_cnt < settle_limit)
            settle_cnt <= settle_cnt + 1'b1;
    end

    // ************************************************************
    // Status register
    // ************************************************************
    wire       dn_ready  = link_detected && link_caps_known;
    wire       tx_locked = tx_active && remote_locked && input_valid && port_mode_ok;
    wire [1:0] port_rep  = (tx_locked && port0_single) ? acls_pkg::PORT_MODE_SINGLE_PORT0
                                                       : acls_pkg::PORT_MODE_NONE;
    wire [7:0] next_sts  = {dn_ready, tx_locked, port_rep, tmds_recovering,
                            hdmi_pll_locked, no_clk, rate_settled};

    // Live copy of conditions; no write path reaches it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            serial_link_state <= acls_pkg::SERIAL_LINK_STATE_RST;
        else
            serial_link_state <= next_sts;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_TDM_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(tdm_on) |=> tdm_conv_enable ##0 audio_clk_from_conv)
        else $error("converter not enabled after control bit set");

    AST_CONV_CLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tdm_conv_enable |-> audio_clk_from_conv)
        else $error("converter on but audio clock not from converter");

    AST_I2S_ON: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sound_path_control[acls_pkg::CTL_HDMI_I2S_OUT_BIT] && !audio_src_local |=> i2s_out_enable)
        else $error("I2S output not enabled");

    AST_I2S_GATED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        audio_src_local |=> !i2s_out_enable)
        else $error("I2S output driven while local source selected");

    AST_FIFO_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trig_type.hit || trig_sound.hit || trig_video.hit || trig_regen.hit |=> fifo_clear)
        else $error("FIFO clear missing after trigger");

    AST_NO_SPURIOUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fifo_clear |-> $past(any_hit))
        else $error("FIFO clear without a trigger");

    AST_STS_READONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && rd_sts |=> $stable(sound_path_control))
        else $error("status write disturbed control register");

    AST_LINK_READY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        serial_link_state[7] |-> $past(link_detected) && $past(link_caps_known))
        else $error("link ready without connection and capabilities");

    AST_TX_QUAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        serial_link_state[6] |-> $past(input_valid) && $past(port_mode_ok) && $past(remote_locked))
        else $error("transmitter status without its qualifiers");

    AST_PORT_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        serial_link_state[6] && $past(port0_single) |-> serial_link_state[5:4] == 2'h1)
        else $error("port mode not single port 0");

    AST_SETTLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(serial_link_state[0]) |-> $past(settle_cnt) >= $past(settle_limit))
        else $error("rate settled before settle time");

    AST_LOW_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> serial_link_state[1] == $past(no_clk))
        else $error("missing clock flag wrong");

    COV_FIFO_CLEAR: cover property (@(posedge sys_clk) disable iff (!rst_n) fifo_clear);
    COV_SETTLED:    cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(serial_link_state[0]));
    COV_TX_LOCKED:  cover property (@(posedge sys_clk) disable iff (!rst_n) serial_link_state[6]);
    COV_I2S_OUT:    cover property (@(posedge sys_clk) disable iff (!rst_n) i2s_out_enable);

endmodule

//--- include/acls_pkg.sv
// Constants shared by the audio configuration and link status register slice
package acls_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] SOUND_PATH_CONTROL_ADDR = 8'h55;
    localparam logic [7:0] SERIAL_LINK_STATE_ADDR  = 8'h5A;
    localparam logic [7:0] SOUND_PATH_CONTROL_RST  = 8'h0C;
    localparam logic [7:0] SERIAL_LINK_STATE_RST   = 8'h00;
    // Writable bits of the control register; 5:4 are reserved and read zero
    localparam logic [7:0] SOUND_PATH_CONTROL_MASK = 8'hCF;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTL_TDM_TO_PARALLEL_BIT     = 7;
    localparam int CTL_HDMI_I2S_OUT_BIT        = 6;
    localparam int CTL_FIFO_CLEAR_ON_TYPE_BIT  = 3;
    localparam int CTL_FIFO_CLEAR_ON_SOUND_BIT = 2;
    localparam int CTL_FIFO_CLEAR_ON_VIDEO_BIT = 1;
    localparam int CTL_FIFO_CLEAR_ON_REGEN_BIT = 0;

    localparam logic [1:0] PORT_MODE_NONE        = 2'h0;
    localparam logic [1:0] PORT_MODE_SINGLE_PORT0 = 2'h1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SETTLE_T0_US   = 40;
    localparam int SETTLE_T1_US   = 80;
    localparam int SETTLE_T2_US   = 320;
    localparam int SETTLE_T3_NS   = 1280000;
    localparam int SETTLE_T0_CYC  = SETTLE_T0_US * 1000 / CLK_PERIOD_NS;
    localparam int SETTLE_T1_CYC  = SETTLE_T1_US * 1000 / CLK_PERIOD_NS;
    localparam int SETTLE_T2_CYC  = SETTLE_T2_US * 1000 / CLK_PERIOD_NS;
    localparam int SETTLE_T3_CYC  = SETTLE_T3_NS / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W   = 15;

    // ************************************************************
    // Widths of watched packet fields and of the frequency measurement and its settings
    // ************************************************************
    localparam int AUDIO_TYPE_W   = 4;
    localparam int CHECKSUM_W     = 8;
    localparam int REGEN_NCTS_W   = 40;
    localparam int FREQ_W         = 8;
    localparam int LOW_LIMIT_W    = 6;
    localparam int TOLERANCE_W    = 3;

endpackage

//--- include/acls_trig_if.sv
// Enable and hit pair between the control bank and one change watcher
`timescale 1ns/10ps
interface acls_trig_if;
    logic en;
    logic hit;
    modport ctl (output en, input hit);
    modport det (input en, output hit);
endinterface

//--- hw/acls_change_det.sv
// Watches one packet field and pulses once per change while armed
`timescale 1ns/10ps
module acls_change_det #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    acls_trig_if.det          trig
);

    logic [W-1:0] last;
    logic         seen;
    wire          differs = sample_valid && seen && (sample != last);

    // ************************************************************
    // Change capture
    // ************************************************************
    // Old value is replaced on every sample, so a persisting value fires once
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            last     <= '0;
            seen     <= 1'b0;
            trig.hit <= 1'b0;
        end
        else
        begin
            trig.hit <= differs && trig.en;
            if (sample_valid)
            begin
                last <= sample;
                seen <= 1'b1;
            end
        end
    end

    AST_ONE_PER_CHANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trig.hit |=> !trig.hit || ($past(sample) != $past(sample, 2)))
        else $error("change watcher fired twice for one change");

endmodule

//--- tb/acls_far_end.sv
// Behavioural far-end deserializer that comes up in steps after attach
`timescale 1ns/10ps
module acls_far_end (
    input  wire logic sys_clk,
    input  wire logic attach,
    output logic      link_detected,
    output logic      link_caps_known,
    output logic      tx_active,
    output logic      remote_locked,
    output logic      port_mode_ok
);
    logic [3:0] step_cnt = 4'h0;
    // Bring-up ladder; a pulled cable drops every condition at once
    always @(posedge sys_clk)
    begin
        step_cnt <= attach ? step_cnt + {3'h0, step_cnt != 4'hF} : 4'h0;
    end
    // Capabilities lag detection, lock lags port mode, as a real far end would
    assign link_detected   = step_cnt >= 4'h3;
    assign link_caps_known = step_cnt >= 4'h6;
    assign port_mode_ok    = step_cnt >= 4'h8;
    assign tx_active       = step_cnt >= 4'h9;
    assign remote_locked   = step_cnt >= 4'hB;
endmodule

//--- tb/audio_cfg_link_status_regs_tb_top.sv
// Self-checking bench for the audio configuration and link status slice
`timescale 1ns/10ps
module audio_cfg_link_status_regs_tb_top;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, freq_mhz = 8'h32;
    logic audio_src_local = 1'b0, attach = 1'b0, input_valid = 1'b0;
    logic port0_single = 1'b0, tmds_recovering = 1'b0, hdmi_pll_locked = 1'b0;
    logic freq_meas_valid = 1'b0;
    logic [1:0] settle_time_select = 2'h0;
    logic [3:0] smp_vld = 4'h0;
    logic [39:0] smp_val = 40'h0;
    logic [7:0] reg_rdata, serial_link_state;
    logic reg_rvalid, tdm_conv_enable, audio_clk_from_conv, i2s_out_enable;
    logic audio_from_local_pins, fifo_clear;
    logic link_detected, link_caps_known, tx_active, remote_locked, port_mode_ok;
    int miscompares = 0;
    int tests_run = 0;
    // One shared sample bus fans out to the four packet watchers
    wire logic regen_packet_valid = smp_vld[0];
    wire logic video_frame_valid = smp_vld[1];
    wire logic sound_frame_valid = smp_vld[2];
    wire logic audio_type_valid = smp_vld[3];
    wire logic [acls_pkg::REGEN_NCTS_W-1:0] regen_n_cts = smp_val;
    wire logic [acls_pkg::CHECKSUM_W-1:0] video_frame_csum = smp_val[7:0];
    wire logic [acls_pkg::CHECKSUM_W-1:0] sound_frame_csum = smp_val[7:0];
    wire logic [acls_pkg::AUDIO_TYPE_W-1:0] audio_type = smp_val[3:0];
    // Held at their usual programmed values
    wire logic [acls_pkg::LOW_LIMIT_W-1:0] low_rate_limit = 6'h06;
    wire logic [acls_pkg::TOLERANCE_W-1:0] rate_tolerance = 3'h2;

    // Short settle limits keep the run brief
    acls_regs #(.SETTLE_T2_CYCLES(20), .SETTLE_T3_CYCLES(40)) dut_u (
        .sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .reg_rvalid, .audio_src_local, .audio_type_valid, .audio_type,
        .sound_frame_valid, .sound_frame_csum, .video_frame_valid,
        .video_frame_csum, .regen_packet_valid, .regen_n_cts, .link_detected,
        .link_caps_known, .tx_active, .remote_locked, .input_valid, .port_mode_ok,
        .port0_single, .tmds_recovering, .hdmi_pll_locked, .freq_meas_valid,
        .freq_mhz, .low_rate_limit, .rate_tolerance, .settle_time_select,
        .tdm_conv_enable, .audio_clk_from_conv, .i2s_out_enable,
        .audio_from_local_pins, .fifo_clear, .serial_link_state);
    acls_far_end far_u (.sys_clk, .attach, .link_detected, .link_caps_known,
        .tx_active, .remote_locked, .port_mode_ok);

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Answer stands one cycle, so it is sampled just after the taking edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata, exp);
    endtask
    // Clear pulse stands in the second cycle after the sampling edge and must not repeat
    task automatic sample(input int i, input logic [39:0] v, input logic exp);
        @(posedge sys_clk);
        smp_vld <= 4'h1 << i;
        smp_val <= v;
        @(posedge sys_clk);
        smp_vld <= 4'h0;
        tick(1);
        #1;
        chk(fifo_clear, exp);
        @(posedge sys_clk);
        #1;
        chk(fifo_clear, 1'b0);
    endtask
    task automatic freq_pulse(input logic [7:0] v);
        @(posedge sys_clk);
        freq_mhz <= v;
        freq_meas_valid <= 1'b1;
        @(posedge sys_clk);
        freq_meas_valid <= 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        rd_chk(acls_pkg::SOUND_PATH_CONTROL_ADDR, 8'h0C);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h00);
        chk({tdm_conv_enable, i2s_out_enable, fifo_clear}, 3'h0);
    endtask
    // Reset in mid-run must bring back the control default and clear status
    task automatic t_mid_reset;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        t_reset;
    endtask
    task automatic t_ctrl;
        wr(acls_pkg::SOUND_PATH_CONTROL_ADDR, 8'hFF);
        rd_chk(acls_pkg::SOUND_PATH_CONTROL_ADDR, 8'hCF);
        chk({tdm_conv_enable, audio_clk_from_conv, i2s_out_enable, audio_from_local_pins}, 4'hE);
        @(posedge sys_clk);
        audio_src_local <= 1'b1;
        tick(2);
        #1;
        chk({tdm_conv_enable, audio_clk_from_conv, i2s_out_enable, audio_from_local_pins}, 4'hD);
        wr(acls_pkg::SOUND_PATH_CONTROL_ADDR, 8'h40);
        audio_src_local <= 1'b0;
        tick(2);
        #1;
        chk({tdm_conv_enable, audio_clk_from_conv, i2s_out_enable, audio_from_local_pins}, 4'h2);
        rd_chk(8'h33, 8'h00);
    endtask
    // Each watcher alone: disabled change, repeat, real change, persisting value
    task automatic t_fifo;
        for (int i = 0; i < 4; i++)
        begin
            wr(acls_pkg::SOUND_PATH_CONTROL_ADDR, 8'h00);
            sample(i, 40'hA5, 1'b0);
            sample(i, 40'h5A, 1'b0);
            wr(acls_pkg::SOUND_PATH_CONTROL_ADDR, 8'h01 << i);
            sample(i, 40'h5A, 1'b0);
            sample(i, 40'hC3, 1'b1);
            sample(i, 40'hC3, 1'b0);
        end
    endtask
    task automatic t_freq;
        @(posedge sys_clk);
        settle_time_select <= 2'h2;
        freq_mhz <= 8'h06;
        tick(3);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h02);
        freq_pulse(8'h32);
        tick(5);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h00);
        tick(25);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h01);
        freq_pulse(8'h34);
        tick(2);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h01);
        freq_pulse(8'h38);
        tick(2);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h00);
        tick(30);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h01);
        // Longest settle choice, shortened by the bench parameter to 40 cycles
        @(posedge sys_clk);
        settle_time_select <= 2'h3;
        freq_pulse(8'h40);
        tick(25);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h00);
        tick(20);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h01);
    endtask
    task automatic t_status;
        @(posedge sys_clk);
        attach <= 1'b1;
        {input_valid, port0_single, tmds_recovering, hdmi_pll_locked} <= 4'hF;
        tick(20);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'hDD);
        chk(serial_link_state, 8'hDD);
        wr(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h00);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'hDD);
        @(posedge sys_clk);
        {input_valid, tmds_recovering} <= 2'h0;
        tick(3);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h85);
        @(posedge sys_clk);
        {input_valid, port0_single, hdmi_pll_locked} <= 3'h4;
        tick(3);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'hC1);
        @(posedge sys_clk);
        attach <= 1'b0;
        tick(3);
        rd_chk(acls_pkg::SERIAL_LINK_STATE_ADDR, 8'h01);
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence after a two-cycle reset
    initial
    begin
        tick(2);
        rst_n <= 1'b1;
        t_reset;
        t_ctrl;
        t_fifo;
        t_freq;
        t_status;
        t_mid_reset;
        end_sim;
    end
    // Watchdog: the tests need well under a tenth of this span
    initial
    begin
        #400000;
        miscompares++;
        end_sim;
    end
endmodule
